/* verilog/sswc_pkg.sv */
package sswc_pkg;
	// register byte offsets
	localparam logic [11:0] SSWC_OFS_CTRL = 12'h000;
	localparam logic [11:0] SSWC_OFS_STATUS = 12'h004;
	localparam logic [11:0] SSWC_OFS_IRQ_STAT = 12'h008;
	localparam logic [11:0] SSWC_OFS_IRQ_MASK = 12'h00C;
	localparam logic [11:0] SSWC_OFS_TAU = 12'h010;
	localparam logic [11:0] SSWC_OFS_WKT = 12'h014;
	localparam logic [11:0] SSWC_OFS_ANA = 12'h018;
	localparam logic [11:0] SSWC_OFS_ANA_LO = 12'h01C;
	localparam logic [11:0] SSWC_OFS_ANA_HI = 12'h020;
	localparam logic [11:0] SSWC_OFS_PIN = 12'h024;
	localparam logic [11:0] SSWC_OFS_CAUSE = 12'h028;
	// control register fields
	localparam int SSWC_CTRL_MODE = 0;      // 0 app-controlled, 1 periodic dormant
	localparam int SSWC_CTRL_SLEEP = 1;     // write 1: enter deepest sleep in app mode (self clearing)
	localparam int SSWC_CTRL_WKT_EN = 2;    // wakeup timer enable in app mode
	localparam int SSWC_CTRL_TAU_EN = 3;    // periodic dormant cycle enable
	localparam int SSWC_CTRL_ACT_DONE = 4;  // stack: active period over
	// analog config fields
	localparam int SSWC_ANA_EN = 0;
	localparam int SSWC_ANA_SEL = 1;        // 0 channel a, 1 channel b
	localparam int SSWC_ANA_CMP_LSB = 2;    // two bits of compare kind
	// wake cause / irq bits
	localparam int SSWC_NCAUSE = 8;
	localparam int SSWC_C_TAU = 0;
	localparam int SSWC_C_WKT = 1;
	localparam int SSWC_C_ANA = 2;
	localparam int SSWC_C_PIN_A = 3;
	localparam int SSWC_C_PIN_B = 4;
	localparam int SSWC_C_RESET = 5;
	localparam int SSWC_C_PWR = 6;
	localparam int SSWC_C_EPO = 7;
	// wakeup timer margin before tau expiry, in ticks
	localparam logic [31:0] SSWC_WKT_MARGIN = 32'h0000_0004;
	localparam logic [31:0] SSWC_RESET_VAL = 32'h0000_0000;
	// timing: one tick per microsecond at 50 MHz
	localparam int SSWC_CLK_HZ = 50_000_000;
	localparam int SSWC_TICK_NS = 1000;
	localparam int SSWC_TICK_CYC = (SSWC_TICK_NS * (SSWC_CLK_HZ / 1_000_000) + 999) / 1000;
	// reboot duration in ticks
	localparam logic [15:0] SSWC_BOOT_TICKS = 16'h0010;

	// analog compare kinds
	typedef enum logic [1:0] {SSWC_CMP_ABOVE, SSWC_CMP_BELOW, SSWC_CMP_INSIDE, SSWC_CMP_OUTSIDE} sswc_cmp_t;
	// pin trigger kinds
	typedef enum logic [2:0] {SSWC_PT_OFF, SSWC_PT_HIGH, SSWC_PT_LOW, SSWC_PT_RISE, SSWC_PT_FALL, SSWC_PT_BOTH}
		sswc_pin_trig_t;
	// power states
	typedef enum logic [2:0] {SSWC_ST_OFF, SSWC_ST_BOOT, SSWC_ST_ACTIVE, SSWC_ST_SLEEP, SSWC_ST_EPO} sswc_state_t;
endpackage

/* verilog/sswc_pin_det.sv */
`timescale 1ns/1ps
`default_nettype none
// level or edge wake detector for one pin
module sswc_pin_det
	import sswc_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic rstn,
	// pin and configuration
	input wire logic pin,
	input wire logic [2:0] trig,
	// detection
	output logic hit
);
	logic prev_q;
	logic init_q;

	// previous pin sample, seeded on first cycle to avoid a false edge
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			prev_q <= 1'b0;
			init_q <= 1'b0;
		end else begin
			prev_q <= pin;
			init_q <= 1'b1;
		end
	end

	// selected level or edge condition
	always_comb begin
		hit = 1'b0;
		unique case (trig)
			SSWC_PT_HIGH: hit = pin;
			SSWC_PT_LOW: hit = !pin;
			SSWC_PT_RISE: hit = init_q && pin && !prev_q;
			SSWC_PT_FALL: hit = init_q && !pin && prev_q;
			SSWC_PT_BOTH: hit = init_q && (pin != prev_q);
			default: hit = 1'b0;
		endcase
	end
endmodule
`default_nettype wire

/* verilog/sswc_top.sv */
// Functional notes
// - power up with request asserted: go active
// - power up with request off: deepest sleep
// - tau timer wakes only in periodic mode
// - wakeup timer fires after interval, optional
// - periodic mode: wakeup timer slightly before tau
// - analog threshold or window wakes in sleep
// - one analog channel armed, new replaces old
// - wake pins wake on level or edge
// - reset pin with request on: reset, wake
// - reset pin with request off: emergency off
// - request off-to-on transition wakes deepest sleep
// - app mode may sleep indefinitely untimed
// - periodic mode cycles active and inactive itself
// - any wake source works while dormant
// - wake causes reboot then active state
`timescale 1ns/1ps
`default_nettype none
module sswc_top
	import sswc_pkg::*;
#(
	parameter int ANA_W = 12
) (
	// clock and reset
	input wire logic CLK,
	input wire logic RSTN,
	// apb slave
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [11:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	// wake inputs, active levels as named
	input wire logic POWER_REQ,
	input wire logic EXT_RESET_N,
	input wire logic WAKE_PIN_A,
	input wire logic WAKE_PIN_B,
	input wire logic [ANA_W-1:0] ANALOG_WAKE_CHANNEL_A,
	input wire logic [ANA_W-1:0] ANALOG_WAKE_CHANNEL_B,
	// power state outputs
	output logic ACTIVE,
	output logic DEEPEST_SLEEP_STATE,
	output logic CORE_RESET_N,
	output logic EMERGENCY_OFF,
	output logic IRQ
);
	// refuse sample widths and tick dividers that the fields and counters cannot serve
	if (ANA_W < 1 || ANA_W > 32) begin : g_bad_ana_w
		$error("sswc_top: ANA_W out of range");
	end
	if (SSWC_TICK_CYC < 1 || SSWC_TICK_CYC > 256) begin : g_bad_tick
		$error("sswc_top: tick divider does not fit its counter");
	end

	sswc_state_t state_q;
	logic [31:0] ctrl_q;
	logic [31:0] tau_q;
	logic [31:0] wkt_q;
	logic [31:0] ana_q;
	logic [ANA_W-1:0] ana_lo_q;
	logic [ANA_W-1:0] ana_hi_q;
	logic [5:0] pin_cfg_q;
	logic [SSWC_NCAUSE-1:0] irq_stat_q;
	logic [SSWC_NCAUSE-1:0] irq_mask_q;
	logic [SSWC_NCAUSE-1:0] cause_q;
	logic [31:0] tau_cnt_q;
	logic [31:0] wkt_cnt_q;
	logic [15:0] boot_cnt_q;
	logic [7:0] tick_cnt_q;
	logic tick;
	logic pwr_prev_q;
	logic rst_prev_q;
	logic pwr_seen_q;
	logic sleep_cmd_q;
	logic act_done_q;
	logic wr_en;
	logic rd_en;
	logic mode_psm;
	logic pin_a_hit;
	logic pin_b_hit;
	logic ana_hit;
	logic [ANA_W-1:0] ana_val;
	logic [SSWC_NCAUSE-1:0] src;
	logic wake;
	logic reset_edge;
	logic pwr_rise;
	logic [31:0] wkt_limit;

	assign wr_en = PSEL && PENABLE && PWRITE;
	assign rd_en = PSEL && !PENABLE && !PWRITE; // setup cycle of a read
	assign mode_psm = ctrl_q[SSWC_CTRL_MODE];
	assign reset_edge = rst_prev_q && !EXT_RESET_N;
	assign pwr_rise = !pwr_prev_q && POWER_REQ;

	// microsecond tick enable
	assign tick = (tick_cnt_q == 8'(SSWC_TICK_CYC - 1));
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			tick_cnt_q <= 8'h00;
		end else if (tick) begin
			tick_cnt_q <= 8'h00;
		end else begin
			tick_cnt_q <= tick_cnt_q + 8'h01;
		end
	end

	// input history for edge detection
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			pwr_prev_q <= 1'b0;
			rst_prev_q <= 1'b1;
		end else begin
			pwr_prev_q <= POWER_REQ;
			rst_prev_q <= EXT_RESET_N;
		end
	end

	// wake pin detectors
	sswc_pin_det u_pin_a (
		.clk(CLK),
		.rstn(RSTN),
		.pin(WAKE_PIN_A),
		.trig(pin_cfg_q[2:0]),
		.hit(pin_a_hit)
	);
	sswc_pin_det u_pin_b (
		.clk(CLK),
		.rstn(RSTN),
		.pin(WAKE_PIN_B),
		.trig(pin_cfg_q[5:3]),
		.hit(pin_b_hit)
	);

	// analog compare on the single armed channel
	assign ana_val = ana_q[SSWC_ANA_SEL] ? ANALOG_WAKE_CHANNEL_B : ANALOG_WAKE_CHANNEL_A;
	always_comb begin
		ana_hit = 1'b0;
		unique case (sswc_cmp_t'(ana_q[SSWC_ANA_CMP_LSB +: 2]))
			SSWC_CMP_ABOVE: ana_hit = ana_val > ana_hi_q;
			SSWC_CMP_BELOW: ana_hit = ana_val < ana_lo_q;
			SSWC_CMP_INSIDE: ana_hit = ana_val >= ana_lo_q && ana_val <= ana_hi_q;
			SSWC_CMP_OUTSIDE: ana_hit = ana_val < ana_lo_q || ana_val > ana_hi_q;
		endcase
		ana_hit = ana_hit && ana_q[SSWC_ANA_EN];
	end

	// wakeup timer limit: in periodic mode derived from tau minus margin
	assign wkt_limit = (tau_q > SSWC_WKT_MARGIN) ? tau_q - SSWC_WKT_MARGIN : 32'h0000_0001;

	// wake sources, the tau and wakeup timer sources gated by mode
	always_comb begin
		src = '0;
		src[SSWC_C_TAU] = mode_psm && ctrl_q[SSWC_CTRL_TAU_EN] && tau_cnt_q >= tau_q;
		src[SSWC_C_WKT] = (mode_psm ? ctrl_q[SSWC_CTRL_TAU_EN] : ctrl_q[SSWC_CTRL_WKT_EN])
			&& wkt_cnt_q >= (mode_psm ? wkt_limit : wkt_q);
		src[SSWC_C_ANA] = ana_hit;
		src[SSWC_C_PIN_A] = pin_a_hit;
		src[SSWC_C_PIN_B] = pin_b_hit;
		src[SSWC_C_RESET] = reset_edge && POWER_REQ;
		src[SSWC_C_PWR] = pwr_rise;
		src[SSWC_C_EPO] = 1'b0;
	end
	assign wake = |src;

	// power state machine
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			state_q <= SSWC_ST_OFF;
			boot_cnt_q <= 16'h0000;
			cause_q <= '0;
			pwr_seen_q <= 1'b0;
		end else begin
			if (state_q != SSWC_ST_OFF && reset_edge && !POWER_REQ) begin
				state_q <= SSWC_ST_EPO;
				cause_q <= SSWC_NCAUSE'(1) << SSWC_C_EPO;
			end else begin
				unique case (state_q)
					SSWC_ST_OFF: begin
						pwr_seen_q <= 1'b1;
						state_q <= POWER_REQ ? SSWC_ST_BOOT : SSWC_ST_SLEEP;
						boot_cnt_q <= 16'h0000;
					end
					SSWC_ST_BOOT: begin
						if (reset_edge) begin
							boot_cnt_q <= 16'h0000;
						end else if (tick) begin
							boot_cnt_q <= boot_cnt_q + 16'h0001;
						end
						if (boot_cnt_q >= SSWC_BOOT_TICKS) begin
							state_q <= SSWC_ST_ACTIVE;
						end
					end
					SSWC_ST_ACTIVE: begin
						if (reset_edge) begin
							state_q <= SSWC_ST_BOOT;
							boot_cnt_q <= 16'h0000;
							cause_q <= SSWC_NCAUSE'(1) << SSWC_C_RESET;
						end else if ((!mode_psm && sleep_cmd_q) || (mode_psm && act_done_q)) begin
							state_q <= SSWC_ST_SLEEP;
						end
					end
					SSWC_ST_SLEEP: begin
						if (wake) begin
							state_q <= SSWC_ST_BOOT;
							boot_cnt_q <= 16'h0000;
							cause_q <= src;
						end
					end
					SSWC_ST_EPO: begin
						if (pwr_rise) begin
							state_q <= SSWC_ST_BOOT;
							boot_cnt_q <= 16'h0000;
							cause_q <= SSWC_NCAUSE'(1) << SSWC_C_PWR;
						end
					end
					default: state_q <= SSWC_ST_OFF;
				endcase
			end
		end
	end

	// sleep timers run only while in deepest sleep
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			tau_cnt_q <= 32'h0000_0000;
			wkt_cnt_q <= 32'h0000_0000;
		end else if (state_q != SSWC_ST_SLEEP) begin
			tau_cnt_q <= 32'h0000_0000;
			wkt_cnt_q <= 32'h0000_0000;
		end else if (tick) begin
			if (tau_cnt_q != 32'hFFFF_FFFF) tau_cnt_q <= tau_cnt_q + 32'h0000_0001;
			if (wkt_cnt_q != 32'hFFFF_FFFF) wkt_cnt_q <= wkt_cnt_q + 32'h0000_0001;
		end
	end

	// configuration registers written over apb
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			ctrl_q <= SSWC_RESET_VAL;
			tau_q <= SSWC_RESET_VAL;
			wkt_q <= SSWC_RESET_VAL;
			ana_q <= SSWC_RESET_VAL;
			ana_lo_q <= '0;
			ana_hi_q <= '0;
			pin_cfg_q <= '0;
			irq_mask_q <= '0;
		end else if (wr_en) begin
			unique case (PADDR)
				SSWC_OFS_CTRL: begin
					// command bits are pulses and never stored
					ctrl_q <= SSWC_RESET_VAL;
					ctrl_q[SSWC_CTRL_MODE] <= PWDATA[SSWC_CTRL_MODE];
					ctrl_q[SSWC_CTRL_WKT_EN] <= PWDATA[SSWC_CTRL_WKT_EN];
					ctrl_q[SSWC_CTRL_TAU_EN] <= PWDATA[SSWC_CTRL_TAU_EN];
				end
				SSWC_OFS_TAU: tau_q <= PWDATA;
				SSWC_OFS_WKT: wkt_q <= PWDATA;
				SSWC_OFS_ANA: ana_q <= {28'h0000000, PWDATA[3:0]};
				SSWC_OFS_ANA_LO: ana_lo_q <= PWDATA[ANA_W-1:0];
				SSWC_OFS_ANA_HI: ana_hi_q <= PWDATA[ANA_W-1:0];
				SSWC_OFS_PIN: pin_cfg_q <= PWDATA[5:0];
				SSWC_OFS_IRQ_MASK: irq_mask_q <= PWDATA[SSWC_NCAUSE-1:0];
				default: ;
			endcase
		end
	end

	// one-shot sleep entry and active-done commands
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			sleep_cmd_q <= 1'b0;
			act_done_q <= 1'b0;
		end else begin
			sleep_cmd_q <= wr_en && PADDR == SSWC_OFS_CTRL && PWDATA[SSWC_CTRL_SLEEP];
			act_done_q <= wr_en && PADDR == SSWC_OFS_CTRL && PWDATA[SSWC_CTRL_ACT_DONE];
		end
	end

	// sticky wake status, set wins over write-one clear
	// events outside sleep (reset pin, emergency off, power return) are flagged too
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			irq_stat_q <= '0;
		end else begin
			irq_stat_q <= (irq_stat_q & ~((wr_en && PADDR == SSWC_OFS_IRQ_STAT) ? PWDATA[SSWC_NCAUSE-1:0] : '0))
				| ((state_q == SSWC_ST_SLEEP && wake) ? src : '0)
				| ((state_q != SSWC_ST_OFF && reset_edge && POWER_REQ) ? SSWC_NCAUSE'(1) << SSWC_C_RESET : '0)
				| ((state_q != SSWC_ST_OFF && reset_edge && !POWER_REQ) ? SSWC_NCAUSE'(1) << SSWC_C_EPO : '0)
				| ((state_q == SSWC_ST_EPO && pwr_rise) ? SSWC_NCAUSE'(1) << SSWC_C_PWR : '0);
		end
	end

	// apb read data and answers, zero wait states
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			PRDATA <= 32'h0000_0000;
			PREADY <= 1'b0;
			PSLVERR <= 1'b0;
		end else begin
			PREADY <= PSEL && !PENABLE;
			PSLVERR <= 1'b0;
			// read data latched at setup so it stands through the access cycle
			if (rd_en) begin
				unique case (PADDR)
					SSWC_OFS_CTRL: PRDATA <= ctrl_q;
					SSWC_OFS_STATUS: PRDATA <= {27'h0000000, pwr_seen_q, 1'b0, 3'(state_q)};
					SSWC_OFS_IRQ_STAT: PRDATA <= {24'h000000, irq_stat_q};
					SSWC_OFS_IRQ_MASK: PRDATA <= {24'h000000, irq_mask_q};
					SSWC_OFS_TAU: PRDATA <= tau_q;
					SSWC_OFS_WKT: PRDATA <= wkt_q;
					SSWC_OFS_ANA: PRDATA <= ana_q;
					SSWC_OFS_ANA_LO: PRDATA <= 32'(ana_lo_q);
					SSWC_OFS_ANA_HI: PRDATA <= 32'(ana_hi_q);
					SSWC_OFS_PIN: PRDATA <= {26'h0000000, pin_cfg_q};
					SSWC_OFS_CAUSE: PRDATA <= {24'h000000, cause_q};
					default: PRDATA <= 32'h0000_0000;
				endcase
			end
		end
	end

	// registered state outputs
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			ACTIVE <= 1'b0;
			DEEPEST_SLEEP_STATE <= 1'b0;
			CORE_RESET_N <= 1'b0;
			EMERGENCY_OFF <= 1'b0;
			IRQ <= 1'b0;
		end else begin
			ACTIVE <= state_q == SSWC_ST_ACTIVE;
			DEEPEST_SLEEP_STATE <= state_q == SSWC_ST_SLEEP;
			CORE_RESET_N <= state_q == SSWC_ST_ACTIVE;
			EMERGENCY_OFF <= state_q == SSWC_ST_EPO;
			IRQ <= |(irq_stat_q & irq_mask_q);
		end
	end
endmodule
`default_nettype wire

/* tb/sswc_top_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
// power state checks on the top ports
module sswc_top_asserts (
	// clock and reset
	input wire logic CLK,
	input wire logic RSTN,
	// wake inputs
	input wire logic POWER_REQ,
	input wire logic EXT_RESET_N,
	// state outputs
	input wire logic ACTIVE,
	input wire logic DEEPEST_SLEEP_STATE,
	input wire logic CORE_RESET_N,
	input wire logic EMERGENCY_OFF
);
	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (!RSTN);
	// power-up picks active or sleep from the request level
	a_up_active: assert property ($rose(RSTN) && POWER_REQ |-> !DEEPEST_SLEEP_STATE [*8] ##[1:900] ACTIVE)
		else $error("power-up with request did not reach active");
	a_up_sleep: assert property ($rose(RSTN) && !POWER_REQ |-> ##[1:6] DEEPEST_SLEEP_STATE)
		else $error("power-up without request did not sleep");
	// reset pin reacts by request level
	a_rst_wake: assert property ($fell(EXT_RESET_N) && POWER_REQ && DEEPEST_SLEEP_STATE
		|-> ##[1:6] (!DEEPEST_SLEEP_STATE && !EMERGENCY_OFF))
		else $error("reset pin did not wake");
	a_rst_core: assert property ($fell(EXT_RESET_N) && POWER_REQ && ACTIVE |-> ##[1:6] !CORE_RESET_N)
		else $error("reset pin did not reset the core");
	a_emerg_off: assert property ($fell(EXT_RESET_N) && !POWER_REQ && (ACTIVE || DEEPEST_SLEEP_STATE)
		|-> ##[1:6] EMERGENCY_OFF)
		else $error("no emergency off");
	a_emerg_hold: assert property (EMERGENCY_OFF && !POWER_REQ |=> EMERGENCY_OFF)
		else $error("emergency off left without request");
	a_req_wake: assert property ($rose(POWER_REQ) && DEEPEST_SLEEP_STATE |-> ##[1:6] !DEEPEST_SLEEP_STATE)
		else $error("request rise did not wake");
	// every wake reboots, then runs active
	a_boot_then: assert property ($fell(DEEPEST_SLEEP_STATE) && !EMERGENCY_OFF |-> !ACTIVE [*8] ##[1:900] ACTIVE)
		else $error("wake did not reboot into active");
	a_core_boot: assert property ($rose(CORE_RESET_N) |-> ACTIVE && !$past(DEEPEST_SLEEP_STATE) && !$past(EMERGENCY_OFF))
		else $error("core released without a reboot");
endmodule
`default_nettype wire

/* tb/sswc_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
// host application and wake sources
module sswc_host_model (
	// clock
	input wire logic clk,
	// apb master
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [11:0] paddr,
	output logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	// wake sources
	output logic power_req,
	output logic ext_reset_n,
	output logic pin_a,
	output logic pin_b,
	output logic [11:0] ana_a,
	output logic [11:0] ana_b
);
	// idle levels
	initial begin
		{psel, penable, pwrite, paddr, pwdata} = '0;
		{power_req, pin_a, pin_b, ana_a, ana_b} = '0;
		ext_reset_n = 1'b1;
	end
	// one transfer, held until pready
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		q = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
		pwdata <= ~d; // released data is not kept
	endtask
	// each app-mode sleep is commanded here
	task automatic sleep_cmd(input logic [31:0] c);
		logic [31:0] q;
		xfer(1'b1, 12'h000, c | 32'h2, q);
	endtask
endmodule
`default_nettype wire

/* tb/tb_sleep_state_wakeup_control.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin n_compared++; if ((s) !== (e)) begin n_errors++; \
	$display("wrong value %s: expected %h, seen %h", n, e, s); end end
module tb_sleep_state_wakeup_control
	import sswc_pkg::*;
;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	wire logic psel, penable, pwrite, pready, pslverr, power_req, ext_reset_n, pin_a, pin_b;
	wire logic active, dss, core_rst_n, eo, irq;
	wire logic [11:0] paddr, ana_a, ana_b;
	wire logic [31:0] pwdata, prdata;
	int n_errors = 0;
	int n_compared = 0;
	logic [31:0] q;
	logic [5:0] r;
	int span;
	// pin a rows: trigger, level before, level after, wake
	localparam logic [5:0] ROWS [7] = '{6'h0B, 6'h15, 6'h1B, 6'h25, 6'h2B, 6'h1C, 6'h02};
	// clock
	initial begin
		forever #10 clk = ~clk;
	end
	sswc_top i_dut (.CLK(clk), .RSTN(rstn), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
		.PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
		.POWER_REQ(power_req), .EXT_RESET_N(ext_reset_n), .WAKE_PIN_A(pin_a), .WAKE_PIN_B(pin_b),
		.ANALOG_WAKE_CHANNEL_A(ana_a), .ANALOG_WAKE_CHANNEL_B(ana_b), .ACTIVE(active),
		.DEEPEST_SLEEP_STATE(dss), .CORE_RESET_N(core_rst_n), .EMERGENCY_OFF(eo), .IRQ(irq));
	sswc_host_model i_host (.clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .power_req(power_req),
		.ext_reset_n(ext_reset_n), .pin_a(pin_a), .pin_b(pin_b), .ana_a(ana_a), .ana_b(ana_b));
	// verdict
	task automatic close_out();
		if (n_errors == 0 && n_compared > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	// register access
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		i_host.xfer(1'b1, a, d, q);
	endtask
	task automatic rd(input string s, input logic [11:0] a, input logic [31:0] e);
		i_host.xfer(1'b0, a, 32'h0, q);
		`CHK(s, e, q)
		`CHK("slverr", 1'b0, pslverr)
	endtask
	// bounded wait for active or sleep
	task automatic wait_st(input logic act);
		for (int i = 0; i < 2000; i++) begin
			@(posedge clk);
			if ((act ? active : dss) === 1'b1) break;
		end
	endtask
	// wake seen, cause flagged, flag cleared
	task automatic woke(input string s, input int b);
		wait_st(1'b1);
		`CHK(s, 1'b1, active)
		`CHK("irq", 1'b1, irq)
		rd(s, SSWC_OFS_IRQ_STAT, 32'h1 << b);
		wr(SSWC_OFS_IRQ_STAT, 32'hFF);
		repeat (2) @(posedge clk);
		`CHK("irq clear", 1'b0, irq)
	endtask
	task automatic sleep(input logic [31:0] c);
		i_host.sleep_cmd(c);
		wait_st(1'b0);
		`CHK("asleep", 1'b1, dss)
	endtask
	task automatic kick();
		@(posedge clk);
		i_host.ext_reset_n <= 1'b0;
		repeat (3) @(posedge clk);
		i_host.ext_reset_n <= 1'b1;
		repeat (3) @(posedge clk);
	endtask
	// main sequence
	initial begin
		repeat (4) @(posedge clk);
		rstn <= 1'b1;
		wait_st(1'b0);
		`CHK("power-up sleep", 1'b1, dss)
		rd("mask reset", SSWC_OFS_IRQ_MASK, 32'h0);
		rd("unmapped", 12'hFFC, 32'h0);
		wr(SSWC_OFS_IRQ_MASK, 32'hFF);
		wr(SSWC_OFS_IRQ_STAT, 32'hFF);
		wr(SSWC_OFS_TAU, 32'h2);
		wr(SSWC_OFS_CTRL, 32'h8);
		repeat (400) @(posedge clk);
		`CHK("no timed wake", 1'b1, dss)
		foreach (ROWS[i]) begin
			r = ROWS[i];
			@(posedge clk);
			i_host.pin_a <= r[2];
			wr(SSWC_OFS_PIN, {29'h0, r[5:3]});
			repeat (4) @(posedge clk);
			`CHK("pin before", 1'b1, dss)
			i_host.pin_a <= r[1];
			repeat (6) @(posedge clk);
			`CHK("pin wake", ~r[0], dss)
			wr(SSWC_OFS_PIN, 32'h0);
			if (r[0]) begin
				woke("pin cause", SSWC_C_PIN_A);
				sleep(32'h0);
			end
		end
		wr(SSWC_OFS_PIN, 32'h8);
		@(posedge clk);
		i_host.pin_b <= 1'b1;
		repeat (6) @(posedge clk);
		wr(SSWC_OFS_PIN, 32'h0);
		woke("pin b cause", SSWC_C_PIN_B);
		sleep(32'h0);
		@(posedge clk);
		i_host.power_req <= 1'b1;
		woke("request cause", SSWC_C_PWR);
		sleep(32'h0);
		kick();
		woke("reset cause", SSWC_C_RESET);
		kick();
		`CHK("reset in active", 1'b0, active)
		woke("reboot", SSWC_C_RESET);
		@(posedge clk);
		i_host.power_req <= 1'b0;
		kick();
		`CHK("emergency off", 1'b1, eo)
		@(posedge clk);
		i_host.power_req <= 1'b1;
		wait_st(1'b1);
		`CHK("emergency exit", 1'b0, eo)
		wr(SSWC_OFS_IRQ_STAT, 32'hFF);
		sleep(32'h0);
		wr(SSWC_OFS_ANA_HI, 32'h800);
		wr(SSWC_OFS_ANA, 32'h3);
		wr(SSWC_OFS_ANA, 32'h1);
		@(posedge clk);
		i_host.ana_b <= 12'hFFF;
		repeat (6) @(posedge clk);
		`CHK("replaced channel", 1'b1, dss)
		i_host.ana_a <= 12'h900;
		repeat (6) @(posedge clk);
		`CHK("analog wake", 1'b0, dss)
		wr(SSWC_OFS_ANA, 32'h0);
		woke("analog cause", SSWC_C_ANA);
		wr(SSWC_OFS_WKT, 32'h3);
		sleep(32'h4);
		woke("app timer", SSWC_C_WKT);
		sleep(32'h0);
		wr(SSWC_OFS_ANA_LO, 32'h100);
		wr(SSWC_OFS_ANA, 32'hB);
		repeat (6) @(posedge clk);
		`CHK("window idle", 1'b1, dss)
		i_host.ana_b <= 12'h400;
		repeat (6) @(posedge clk);
		wr(SSWC_OFS_ANA, 32'h0);
		woke("window cause", SSWC_C_ANA);
		wr(SSWC_OFS_TAU, 32'hA);
		sleep(32'h19);
		span = 0;
		while (dss === 1'b1 && span < 1000) begin
			@(posedge clk);
			span++;
		end
		`CHK("timer span", 1'b1, span > 250 && span < 330)
		woke("timer cause", SSWC_C_WKT);
		wr(SSWC_OFS_CTRL, 32'h19);
		wait_st(1'b0);
		`CHK("dormant again", 1'b1, dss)
		woke("second cycle", SSWC_C_WKT);
		@(posedge clk);
		rstn <= 1'b0;
		repeat (4) @(posedge clk);
		rstn <= 1'b1;
		wait_st(1'b1);
		`CHK("power-up active", 1'b1, active)
		close_out();
	end
	// watchdog
	initial begin
		#(60000 * 20);
		n_errors++;
		close_out();
	end
endmodule
bind sswc_top sswc_top_asserts i_chk (.CLK(CLK), .RSTN(RSTN), .POWER_REQ(POWER_REQ), .EXT_RESET_N(EXT_RESET_N),
	.ACTIVE(ACTIVE), .DEEPEST_SLEEP_STATE(DEEPEST_SLEEP_STATE), .CORE_RESET_N(CORE_RESET_N),
	.EMERGENCY_OFF(EMERGENCY_OFF));
`default_nettype wire
